//--- verilog/jump_and_mark_branch_unit.sv
// Execution of bit-test branch and jump-and-mark instructions
// Behaviour
// - Bit-test uses bits 0-3 for bit number, bits 5-4 for register and polarity.
// - Condition 11 branches only when selected B bit is zero.
// - Unmet bit-test continues with next sequential instruction.
// - Jump-and-mark recognised when bits 9-15 equal 0 000 010.
// - Jump-and-mark is two words: opcode/mask then effective address.
// - Mask bits 0-8 select conditions like the plain jump mask.
// - Several mask bits set, unless 0006 is among them, means all selected conditions must hold.
// - Mask 0001 overflow, 0002 A non-negative, 0004 A negative, 0006 inverted.
// - Taken jump-and-mark writes program counter at effective address.
// - Taken jump-and-mark resumes at effective address plus one.
// - Failed condition: no store, no branch, continue after both words.
// - Unconditional variant always stores and continues after address.
// - Overflow variant clears overflow when taken, falls through when clear.
// - No-overflow variant taken when clear, never changes overflow.
// - Accumulator non-negative variant taken on zero or positive A.
// - Accumulator negative variant taken only on negative A.
// - Zero variants taken when selected A, B or X is zero.
// - Non-zero variants taken when selected register is non-zero.
// - Switch-set variants taken only when selected switch is set.
// - Switch-clear variants taken only when selected switch is clear.
// - Only program counter, marked word and overflow may change.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module jump_and_mark_branch_unit (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  // Instruction issue
  input wire logic START_IN,
  input wire logic [15:0] INSTR_IN,
  input wire logic [15:0] PC_IN,
  input wire logic ADDR_VALID_IN,
  input wire logic [15:0] ADDR_WORD_IN,
  // Register state
  input wire mark_branch_pkg::cpu_state_t REGS_IN,
  // Results
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic [15:0] NEXT_PC_OUT,
  output logic OVF_CLEAR_OUT,
  output mark_branch_pkg::mem_req_t MEM_OUT,
  output logic UNKNOWN_OUT
);
  mark_branch_pkg::state_t state;
  logic [15:0] instr;
  logic [15:0] pc;
  logic is_mark;
  logic is_bt;
  logic cond;
  localparam logic [15:0] ONE_W = mark_branch_pkg::ONE;

  // Evaluate mask as AND of selected tests, negated when 0006 is set
  function automatic logic mask_ok(input logic [8:0] m, input mark_branch_pkg::cpu_state_t r);
    logic ok;
    ok = 1'b1;
    if (m == mark_branch_pkg::MASK_ALWAYS) begin
      ok = 1'b1;
    end else if ((m & mark_branch_pkg::M_INVERT) == mark_branch_pkg::M_INVERT) begin
      // Inverted form: remaining selected tests must not all hold
      ok = !(
        (m[mark_branch_pkg::M_OVF] ? r.ovf : 1'b1) &&
        (m[mark_branch_pkg::M_AZ] ? (r.a == 16'h0000) : 1'b1) &&
        (m[mark_branch_pkg::M_BZ] ? (r.b == 16'h0000) : 1'b1) &&
        (m[mark_branch_pkg::M_XZ] ? (r.x == 16'h0000) : 1'b1) &&
        (m[mark_branch_pkg::M_S1] ? r.sense[0] : 1'b1) &&
        (m[mark_branch_pkg::M_S2] ? r.sense[1] : 1'b1) &&
        (m[mark_branch_pkg::M_S3] ? r.sense[2] : 1'b1));
    end else begin
      if (m[mark_branch_pkg::M_OVF] && !r.ovf) ok = 1'b0;
      if (m[mark_branch_pkg::M_ANN] && r.a[15]) ok = 1'b0;
      if (m[mark_branch_pkg::M_ANEG] && !r.a[15]) ok = 1'b0;
      if (m[mark_branch_pkg::M_AZ] && r.a != 16'h0000) ok = 1'b0;
      if (m[mark_branch_pkg::M_BZ] && r.b != 16'h0000) ok = 1'b0;
      if (m[mark_branch_pkg::M_XZ] && r.x != 16'h0000) ok = 1'b0;
      if (m[mark_branch_pkg::M_S1] && !r.sense[0]) ok = 1'b0;
      if (m[mark_branch_pkg::M_S2] && !r.sense[1]) ok = 1'b0;
      if (m[mark_branch_pkg::M_S3] && !r.sense[2]) ok = 1'b0;
    end
    return ok;
  endfunction

  // Bit-test condition
  function automatic logic bit_ok(input logic [15:0] w, input mark_branch_pkg::cpu_state_t r);
    logic res;
    res = 1'b0;
    case (w[mark_branch_pkg::BT_SEL_LSB +: 2])
      mark_branch_pkg::BT_A_ONE: res = r.a[w[3:0]];
      mark_branch_pkg::BT_B_ONE: res = r.b[w[3:0]];
      mark_branch_pkg::BT_A_ZERO: res = !r.a[w[3:0]];
      mark_branch_pkg::BT_B_ZERO: res = !r.b[w[3:0]];
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  assign is_mark = (instr[15:mark_branch_pkg::OP_LSB] == mark_branch_pkg::OP_MARK);
  assign is_bt = (instr[15:mark_branch_pkg::OP_BT_LSB] == mark_branch_pkg::OP_BIT_TEST);
  assign cond = is_mark ? mask_ok(instr[8:0], REGS_IN) : bit_ok(instr, REGS_IN);

  // Sequencer
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      state <= mark_branch_pkg::ST_IDLE;
      instr <= 16'h0000;
      pc <= 16'h0000;
    end else begin
      case (state)
        mark_branch_pkg::ST_IDLE: begin
          if (START_IN) begin
            instr <= INSTR_IN;
            pc <= PC_IN;
            state <= mark_branch_pkg::ST_ADDR;
          end
        end
        mark_branch_pkg::ST_ADDR: begin
          if (ADDR_VALID_IN) state <= mark_branch_pkg::ST_DONE;
        end
        default: state <= mark_branch_pkg::ST_IDLE;
      endcase
    end
  end

  // Outputs
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      NEXT_PC_OUT <= 16'h0000;
      OVF_CLEAR_OUT <= 1'b0;
      MEM_OUT <= '0;
      UNKNOWN_OUT <= 1'b0;
    end else begin
      DONE_OUT <= 1'b0;
      OVF_CLEAR_OUT <= 1'b0;
      MEM_OUT.we <= 1'b0;
      UNKNOWN_OUT <= 1'b0;
      if (state == mark_branch_pkg::ST_IDLE && START_IN) BUSY_OUT <= 1'b1;
      if (state == mark_branch_pkg::ST_ADDR && ADDR_VALID_IN) begin
        BUSY_OUT <= 1'b0;
        DONE_OUT <= 1'b1;
        MEM_OUT.addr <= ADDR_WORD_IN;
        MEM_OUT.data <= pc + (ONE_W + ONE_W);
        UNKNOWN_OUT <= !(is_mark || is_bt);
        if (is_mark && cond) begin
          MEM_OUT.we <= 1'b1;
          NEXT_PC_OUT <= ADDR_WORD_IN + ONE_W;
          OVF_CLEAR_OUT <= (instr[8:0] == mark_branch_pkg::MASK_OVF);
        end else if (is_bt && cond) begin
          NEXT_PC_OUT <= ADDR_WORD_IN;
        end else begin
          NEXT_PC_OUT <= pc + (ONE_W + ONE_W);
        end
      end
    end
  end

  // Decision snapshot for the checks below
  logic chk_valid;
  logic [15:0] chk_instr;
  logic [15:0] chk_pc;
  logic [15:0] chk_addr;
  mark_branch_pkg::cpu_state_t chk_regs;
  logic [8:0] chk_mask;
  logic chk_mark;
  logic chk_bt;
  logic chk_sel;
  logic chk_want;
  logic chk_take;
  logic chk_bt_done;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      chk_valid <= 1'b0;
      chk_instr <= 16'h0000;
      chk_pc <= 16'h0000;
      chk_addr <= 16'h0000;
      chk_regs <= '0;
    end else begin
      chk_valid <= (state == mark_branch_pkg::ST_ADDR) && ADDR_VALID_IN;
      if (state == mark_branch_pkg::ST_ADDR && ADDR_VALID_IN) begin
        chk_instr <= instr;
        chk_pc <= pc;
        chk_addr <= ADDR_WORD_IN;
        chk_regs <= REGS_IN;
      end
    end
  end

  assign chk_mask = chk_instr[mark_branch_pkg::MASK_W-1:0];
  assign chk_mark = (chk_instr[mark_branch_pkg::WORD_W-1:mark_branch_pkg::OP_LSB] ==
    mark_branch_pkg::OP_MARK);
  assign chk_bt = (chk_instr[mark_branch_pkg::WORD_W-1:mark_branch_pkg::OP_BT_LSB] ==
    mark_branch_pkg::OP_BIT_TEST);
  assign chk_sel = chk_instr[mark_branch_pkg::BT_SEL_LSB] ?
    chk_regs.b[chk_instr[mark_branch_pkg::BT_BIT_W-1:0]] :
    chk_regs.a[chk_instr[mark_branch_pkg::BT_BIT_W-1:0]];
  assign chk_want = !chk_instr[mark_branch_pkg::BT_POL_BIT];
  assign chk_take = DONE_OUT && chk_mark;
  assign chk_bt_done = DONE_OUT && chk_bt;

  // Completion and condition checks per variant
  AST_SNAPSHOT_DONE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    DONE_OUT == chk_valid)
    else $error("completion not one cycle after address word");

  AST_MARK_ALWAYS: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_ALWAYS) |-> MEM_OUT.we)
    else $error("unconditional mark not taken");

  AST_OVF_SET: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_OVF) |-> (MEM_OUT.we == chk_regs.ovf))
    else $error("overflow mark wrong");

  AST_OVF_CLEARED: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_OVF) |-> (OVF_CLEAR_OUT == chk_regs.ovf))
    else $error("overflow clear wrong");

  AST_NO_OVF: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_NO_OVF) |-> (MEM_OUT.we == !chk_regs.ovf))
    else $error("no-overflow mark wrong");

  AST_NO_OVF_KEEP: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_NO_OVF) |-> !OVF_CLEAR_OUT)
    else $error("no-overflow mark touched overflow");

  AST_ACC_NONNEG: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_ANN) |-> (MEM_OUT.we == !chk_regs.a[15]))
    else $error("non-negative mark wrong");

  AST_ACC_NEG: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_ANEG) |-> (MEM_OUT.we == chk_regs.a[15]))
    else $error("negative mark wrong");

  AST_ZERO_A: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_AZ) |-> (MEM_OUT.we == (chk_regs.a == '0)))
    else $error("A zero mark wrong");

  AST_ZERO_B: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_BZ) |-> (MEM_OUT.we == (chk_regs.b == '0)))
    else $error("B zero mark wrong");

  AST_ZERO_X: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_XZ) |-> (MEM_OUT.we == (chk_regs.x == '0)))
    else $error("X zero mark wrong");

  AST_NONZERO_A: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_ANZ) |-> (MEM_OUT.we == (chk_regs.a != '0)))
    else $error("A non-zero mark wrong");

  AST_NONZERO_B: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_BNZ) |-> (MEM_OUT.we == (chk_regs.b != '0)))
    else $error("B non-zero mark wrong");

  AST_NONZERO_X: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_XNZ) |-> (MEM_OUT.we == (chk_regs.x != '0)))
    else $error("X non-zero mark wrong");

  AST_SWITCH_ONE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_S1) |-> (MEM_OUT.we == chk_regs.sense[0]))
    else $error("switch one mark wrong");

  AST_SWITCH_TWO: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_S2) |-> (MEM_OUT.we == chk_regs.sense[1]))
    else $error("switch two mark wrong");

  AST_SWITCH_THREE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_S3) |-> (MEM_OUT.we == chk_regs.sense[2]))
    else $error("switch three mark wrong");

  AST_SWITCH_ONE_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_S1N) |-> (MEM_OUT.we == !chk_regs.sense[0]))
    else $error("switch one clear mark wrong");

  AST_SWITCH_TWO_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_S2N) |-> (MEM_OUT.we == !chk_regs.sense[1]))
    else $error("switch two clear mark wrong");

  AST_SWITCH_THREE_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_S3N) |-> (MEM_OUT.we == !chk_regs.sense[2]))
    else $error("switch three clear mark wrong");

  AST_AND_TESTS: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::MASK_AZ_BZ) |->
    (MEM_OUT.we == (chk_regs.a == '0 && chk_regs.b == '0)))
    else $error("combined mark wrong");

  AST_INVERT_ALONE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && chk_mask == mark_branch_pkg::M_INVERT) |-> !MEM_OUT.we)
    else $error("bare inverted mask taken");

  // Store and resume checks
  AST_STORE_AT_ADDR: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    MEM_OUT.we |-> (MEM_OUT.addr == chk_addr))
    else $error("store at wrong address");

  AST_MARK_RETURN: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    MEM_OUT.we |-> (MEM_OUT.data == chk_pc + mark_branch_pkg::PC_STEP))
    else $error("stored return address wrong");

  AST_MARK_FALL: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_take && !MEM_OUT.we) |->
    (NEXT_PC_OUT == chk_pc + mark_branch_pkg::PC_STEP && !OVF_CLEAR_OUT))
    else $error("mark fall-through wrong");

  // Bit-test and decode checks
  AST_BT_TAKEN: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_bt_done && chk_sel == chk_want) |-> (NEXT_PC_OUT == chk_addr && !MEM_OUT.we))
    else $error("bit-test branch wrong");

  AST_BT_B_ZERO: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_bt_done && chk_instr[mark_branch_pkg::BT_SEL_LSB +: 2] == mark_branch_pkg::BT_B_ZERO &&
    !chk_sel) |-> (NEXT_PC_OUT == chk_addr))
    else $error("B zero bit-test not taken");

  AST_BT_FALL: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (chk_bt_done && chk_sel != chk_want) |->
    (NEXT_PC_OUT == chk_pc + mark_branch_pkg::PC_STEP && !MEM_OUT.we))
    else $error("bit-test fall-through wrong");

  AST_ONLY_MARK_STORES: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (DONE_OUT && !chk_mark) |-> (!MEM_OUT.we && !OVF_CLEAR_OUT))
    else $error("side effect outside mark");

  AST_DECODE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    DONE_OUT |-> (UNKNOWN_OUT == !(chk_mark || chk_bt)))
    else $error("opcode decode wrong");

  AST_STORE_ONLY_DONE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    MEM_OUT.we |-> DONE_OUT) else $error("store without completion");
  AST_RESUME_AFTER_MARK: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    MEM_OUT.we |-> NEXT_PC_OUT == MEM_OUT.addr + ONE_W) else $error("bad resume address");
  AST_MARK_VALUE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    MEM_OUT.we |-> MEM_OUT.data == $past(pc) + ONE_W + ONE_W) else $error("bad mark value");
  AST_OVF_ONLY_TAKEN: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    OVF_CLEAR_OUT |-> MEM_OUT.we) else $error("overflow cleared on fall-through");
  AST_DONE_AFTER_ADDR: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (state == mark_branch_pkg::ST_ADDR && ADDR_VALID_IN) |=> DONE_OUT) else $error("no completion");
  AST_FALL_THROUGH: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (DONE_OUT && !MEM_OUT.we && !$past(is_bt)) |-> NEXT_PC_OUT == MEM_OUT.data)
    else $error("bad fall-through");
  AST_BUSY_START: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (state == mark_branch_pkg::ST_IDLE && START_IN) |=> BUSY_OUT) else $error("busy missing");
  AST_DONE_PULSE: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    DONE_OUT |=> !DONE_OUT) else $error("done not a pulse");
  COV_TAKEN: cover property (@(posedge CORE_CLK_IN) MEM_OUT.we);
  COV_FALL: cover property (@(posedge CORE_CLK_IN) DONE_OUT && !MEM_OUT.we);
  COV_OVF: cover property (@(posedge CORE_CLK_IN) OVF_CLEAR_OUT);
  COV_BIT_TEST: cover property (@(posedge CORE_CLK_IN) chk_bt_done && NEXT_PC_OUT == chk_addr);
  COV_INVERTED: cover property (@(posedge CORE_CLK_IN)
    chk_take && chk_mask[2:1] == 2'h3 && MEM_OUT.we);
endmodule
`default_nettype wire

//--- verilog/mark_branch_pkg.sv
// Package of constants and carrier types for the jump-and-mark unit
package mark_branch_pkg;
  localparam int WORD_W = 16;
  localparam int MASK_W = 9;
  localparam logic [6:0] OP_MARK = 7'h02;
  localparam logic [9:0] OP_BIT_TEST = 10'h00D;
  localparam int OP_LSB = 9;
  localparam int BT_SEL_LSB = 4;
  localparam logic [1:0] BT_A_ONE = 2'h0;
  localparam logic [1:0] BT_B_ONE = 2'h1;
  localparam logic [1:0] BT_A_ZERO = 2'h2;
  localparam logic [1:0] BT_B_ZERO = 2'h3;
  localparam int M_OVF = 0;
  localparam int M_ANN = 1;
  localparam int M_ANEG = 2;
  localparam int M_AZ = 3;
  localparam int M_BZ = 4;
  localparam int M_XZ = 5;
  localparam int M_S1 = 6;
  localparam int M_S2 = 7;
  localparam int M_S3 = 8;
  localparam logic [8:0] M_INVERT = 9'h006;
  localparam logic [15:0] ONE = 16'h0001;
  localparam int OP_BT_LSB = 6;
  localparam int BT_BIT_W = 4;
  localparam int BT_POL_BIT = 5;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [8:0] MASK_ALWAYS = 9'h000;
  localparam logic [8:0] MASK_OVF = 9'h001;
  localparam logic [8:0] MASK_NO_OVF = 9'h007;
  localparam logic [8:0] MASK_ANN = 9'h002;
  localparam logic [8:0] MASK_ANEG = 9'h004;
  localparam logic [8:0] MASK_AZ = 9'h008;
  localparam logic [8:0] MASK_BZ = 9'h010;
  localparam logic [8:0] MASK_XZ = 9'h020;
  localparam logic [8:0] MASK_ANZ = 9'h00E;
  localparam logic [8:0] MASK_BNZ = 9'h016;
  localparam logic [8:0] MASK_XNZ = 9'h026;
  localparam logic [8:0] MASK_S1 = 9'h040;
  localparam logic [8:0] MASK_S2 = 9'h080;
  localparam logic [8:0] MASK_S3 = 9'h100;
  localparam logic [8:0] MASK_S1N = 9'h046;
  localparam logic [8:0] MASK_S2N = 9'h086;
  localparam logic [8:0] MASK_S3N = 9'h106;
  localparam logic [8:0] MASK_AZ_BZ = 9'h018;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] x;
    logic ovf;
    logic [2:0] sense;
  } cpu_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic we;
  } mem_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DONE = 2'b10
  } state_t;
endpackage

//--- verif/mark_mem_model.sv
// Behavioural main memory and register file beside the unit
`timescale 1ns/1ps
`default_nettype none
module mark_mem_model (
  // Clock and loading
  input wire logic clk_in,
  input wire logic load_in,
  input wire mark_branch_pkg::cpu_state_t preset_in,
  // Requests from the unit
  input wire mark_branch_pkg::mem_req_t mem_in,
  input wire logic ovf_clear_in,
  // Register file
  output mark_branch_pkg::cpu_state_t regs_out
);
  logic [15:0] mem [0:1023];
  always @(posedge clk_in) begin
    if (load_in) begin
      regs_out <= preset_in;
    end else if (ovf_clear_in) begin
      regs_out.ovf <= 1'h0;
    end
  end
  always @(posedge clk_in) begin
    if (mem_in.we) begin
      mem[mem_in.addr[9:0]] <= mem_in.data;
    end
  end
endmodule
`default_nettype wire

//--- verif/jump_and_mark_branch_unit_tb.sv
// Self-checking bench for the jump-and-mark unit
`timescale 1ns/1ps
`default_nettype none
module jump_and_mark_branch_unit_tb;
  localparam logic [15:0] Z = 16'h0000;
  localparam logic [15:0] N = 16'h8000;
  localparam logic [15:0] P = 16'h0100;
  localparam logic [15:0] E = 16'h0200;
  localparam logic [15:0] T = 16'h0201;
  localparam logic [15:0] F = 16'h0102;
  typedef struct packed {
    logic [15:0] i;
    mark_branch_pkg::cpu_state_t s;
    logic [15:0] pc;
    logic [1:0] wc;
  } row_t;
  row_t rows[$];
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic start = 1'h0;
  logic av = 1'h0;
  logic load = 1'h0;
  logic [15:0] instr = 16'h0000;
  mark_branch_pkg::cpu_state_t preset = '0;
  mark_branch_pkg::cpu_state_t regs;
  mark_branch_pkg::mem_req_t mem;
  logic busy, done, clr, unk;
  logic [15:0] npc;
  int n_mismatch = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  jump_and_mark_branch_unit uut (
    .CORE_CLK_IN(clk), .SRST_IN(rst), .START_IN(start), .INSTR_IN(instr),
    .PC_IN(P), .ADDR_VALID_IN(av), .ADDR_WORD_IN(E), .REGS_IN(regs),
    .BUSY_OUT(busy), .DONE_OUT(done), .NEXT_PC_OUT(npc), .OVF_CLEAR_OUT(clr),
    .MEM_OUT(mem), .UNKNOWN_OUT(unk)
  );
  mark_mem_model pm (
    .clk_in(clk), .load_in(load), .preset_in(preset), .mem_in(mem),
    .ovf_clear_in(clr), .regs_out(regs)
  );
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic r(input logic [15:0] i, input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] x, input logic o, input logic [2:0] s, input logic [15:0] pc,
      input logic [1:0] wc);
    rows.push_back('{i, '{a, b, x, o, s}, pc, wc});
  endtask
  task automatic issue(input logic [15:0] i, input logic hold);
    @(posedge clk);
    load <= 1'h1;
    start <= 1'h1;
    instr <= i;
    @(posedge clk);
    load <= 1'h0;
    start <= hold;
    av <= 1'h1;
    #1;
    chk("busy", {15'h0000, busy}, 16'h0001);
    @(posedge clk);
    start <= 1'h0;
    av <= 1'h0;
    #1;
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
  initial begin
    r(16'h0400, Z, Z, Z, 1'h1, 3'h0, T, 2'h2);
    r(16'h0401, Z, Z, Z, 1'h1, 3'h0, T, 2'h3);
    r(16'h0401, Z, Z, Z, 1'h0, 3'h0, F, 2'h0);
    r(16'h0407, Z, Z, Z, 1'h0, 3'h0, T, 2'h2);
    r(16'h0407, Z, Z, Z, 1'h1, 3'h0, F, 2'h0);
    r(16'h0402, N, Z, Z, 1'h0, 3'h0, F, 2'h0);
    r(16'h0404, N, Z, Z, 1'h0, 3'h0, T, 2'h2);
    r(16'h0408, N, Z, Z, 1'h0, 3'h0, F, 2'h0);
    r(16'h0410, N, Z, N, 1'h0, 3'h0, T, 2'h2);
    r(16'h0420, Z, Z, N, 1'h0, 3'h0, F, 2'h0);
    r(16'h040E, N, Z, Z, 1'h0, 3'h0, T, 2'h2);
    r(16'h0416, N, Z, N, 1'h0, 3'h0, F, 2'h0);
    r(16'h0426, Z, Z, N, 1'h0, 3'h0, T, 2'h2);
    r(16'h0440, Z, Z, Z, 1'h0, 3'h1, T, 2'h2);
    r(16'h0480, Z, Z, Z, 1'h0, 3'h5, F, 2'h0);
    r(16'h0500, Z, Z, Z, 1'h0, 3'h4, T, 2'h2);
    r(16'h0446, Z, Z, Z, 1'h0, 3'h6, T, 2'h2);
    r(16'h0486, Z, Z, Z, 1'h0, 3'h2, F, 2'h0);
    r(16'h0506, Z, Z, Z, 1'h0, 3'h4, F, 2'h0);
    r(16'h0418, Z, N, Z, 1'h0, 3'h0, F, 2'h0);
    r(16'h0418, Z, Z, N, 1'h0, 3'h0, T, 2'h2);
    r(16'h0375, Z, Z, Z, 1'h0, 3'h0, E, 2'h0);
    r(16'h0375, Z, 16'h0020, Z, 1'h0, 3'h0, F, 2'h0);
    r(16'h034F, N, Z, Z, 1'h0, 3'h0, E, 2'h0);
    r(16'h036F, N, Z, Z, 1'h0, 3'h0, F, 2'h0);
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk("reset done", {15'h0000, done}, 16'h0000);
    foreach (rows[k]) begin
      pm.mem[512] = 16'hA5A5;
      preset <= rows[k].s;
      issue(rows[k].i, 1'h0);
      chk("done", {15'h0000, done}, 16'h0001);
      chk("next pc", npc, rows[k].pc);
      chk("store", {15'h0000, mem.we}, {15'h0000, rows[k].wc[1]});
      chk("ovf clear", {15'h0000, clr}, {15'h0000, rows[k].wc[0]});
      @(posedge clk);
      #1;
      chk("marked", pm.mem[512], rows[k].wc[1] ? P + 16'h0002 : 16'hA5A5);
    end
    preset <= '0;
    issue(16'h0400, 1'h1);
    @(posedge clk);
    #1;
    chk("refused start", {15'h0000, busy}, 16'h0000);
    issue(16'hFFFF, 1'h0);
    chk("unknown", {14'h0000, unk, mem.we}, 16'h0002);
    @(posedge clk);
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    #1;
    chk("reset busy", {15'h0000, busy}, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
